// *** include/timer_ctl_pkg.sv ***
// constants for the timer control-zero, interrupt select and dead-band block
package timer_ctl_pkg;
   localparam int ADR_W = 16;
   localparam int NTMR  = 2;
   // register indices; byte address is four times the index
   localparam logic [1:0][11:0] IDX_CTL0 = {12'hF0E, 12'hF06};
   localparam logic [1:0][11:0] IDX_CTL1 = {12'hF0F, 12'hF07};
   localparam logic [11:0] IDX_IRQ_STS = 12'hF10;
   localparam logic [11:0] IDX_IRQ_MSK = 12'hF11;
   // control zero fields
   localparam int B_MODE_HI = 7;
   localparam int B_CFG_HI  = 6;
   localparam int B_CFG_LO  = 5;
   localparam int B_DB_HI   = 3;
   localparam int B_DB_LO   = 1;
   localparam int B_CAP     = 0;
   // control one fields
   localparam int B_EN      = 7;
   localparam int B_POL     = 6;
   localparam int B_MODE_LO = 2;
   localparam logic [7:0] CTL_RST       = 8'h00;
   localparam logic [3:0] MODE_PWM_DUAL = 4'hA;
   localparam logic [1:0] CFG_CAP_ONLY  = 2'h2;
   localparam logic [1:0] CFG_RLD_ONLY  = 2'h3;
   localparam logic [7:0] DLY_ONE       = 8'h01;
endpackage

// *** logic/timer_ctl_deadband.sv ***
// control register zero of two timers: mode top bit, irq select, dead-band
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module timer_ctl_deadband (
   input  wire logic                           CLK,
   input  wire logic                           SRST,
   input  wire logic                           CYC_I,
   input  wire logic                           STB_I,
   input  wire logic                           WE_I,
   input  wire logic [timer_ctl_pkg::ADR_W-1:0] ADR_I,
   input  wire logic [3:0]                     SEL_I,
   input  wire logic [31:0]                    DAT_I,
   input  wire logic [timer_ctl_pkg::NTMR-1:0] RELOAD_EVT,
   input  wire logic [timer_ctl_pkg::NTMR-1:0] COMPARE_EVT,
   input  wire logic [timer_ctl_pkg::NTMR-1:0] CAPTURE_EVT,
   input  wire logic [timer_ctl_pkg::NTMR-1:0] PWM_MATCH_EVT,
   output logic      [31:0]                    DAT_O,
   output logic                                ACK_O,
   output logic      [timer_ctl_pkg::NTMR-1:0] TOUT,
   output logic      [timer_ctl_pkg::NTMR-1:0] TOUT_N,
   output logic      [timer_ctl_pkg::NTMR-1:0] TIMER_EN,
   output logic      [7:0]                     TIMER_MODE,
   output logic                                IRQ
);
   import timer_ctl_pkg::*;

   typedef struct packed {
      logic [1:0][7:0] ctl0;
      logic [1:0][7:0] ctl1;
      logic [1:0][7:0] cnt;
      logic [1:0]      main;
      logic [1:0]      comp;
      logic [1:0]      pend_main;
      logic [1:0]      pend_comp;
      logic [1:0]      sts;
      logic [1:0]      msk;
      logic            ack;
      logic [7:0]      dat;
      logic            irq;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   // bus decode shared by the next-state logic and the checks
   logic        req;
   logic        hit_hi;
   logic [11:0] idx;
   logic        wr_take;
   logic        rd_done;

   assign req     = CYC_I & STB_I;
   assign hit_hi  = (ADR_I[15:14] == 2'h0);
   assign idx     = ADR_I[13:2];
   // writes land on the edge that sees ack, as the master expects
   assign wr_take = req & WE_I & SEL_I[0] & state_r.ack & hit_hi;
   assign rd_done = req & ~WE_I & state_r.ack & hit_hi;

   // next state: bus slave, control registers, interrupt, dead-band
   always_comb begin
      logic       en;
      logic       dual;
      logic       pol;
      logic       ev_all;
      logic       ev_sel;
      logic       cap_sel;
      logic [1:0] cfg;
      logic [2:0] code;
      logic [7:0] dly;
      logic [7:0] rd;
      logic [1:0] set;
      logic [1:0] clr;
      en        = 1'b0;
      dual      = 1'b0;
      pol       = 1'b0;
      ev_all    = 1'b0;
      ev_sel    = 1'b0;
      cap_sel   = 1'b0;
      cfg       = 2'h0;
      code      = 3'h0;
      dly       = 8'h00;
      rd        = 8'h00;
      set       = 2'h0;
      clr       = 2'h0;
      state_nxt = state_r;

      // single-wait-state ack; drops the cycle after it was given
      state_nxt.ack = req & ~state_r.ack;

      // read mux; unmapped addresses answer with zero
      if (hit_hi && idx == IDX_IRQ_STS) begin
         rd = {6'h00, state_r.sts};
      end else if (hit_hi && idx == IDX_IRQ_MSK) begin
         rd = {6'h00, state_r.msk};
      end
      for (int t = 0; t < NTMR; t++) begin
         if (hit_hi && idx == IDX_CTL0[t]) begin
            rd = state_r.ctl0[t];
         end
         if (hit_hi && idx == IDX_CTL1[t]) begin
            rd = state_r.ctl1[t];
         end
      end
      state_nxt.dat = (req & ~WE_I & ~state_r.ack) ? rd : 8'h00;

      // register writes through byte lane 0
      if (wr_take && idx == IDX_IRQ_MSK) begin
         state_nxt.msk = DAT_I[1:0];
      end
      for (int t = 0; t < NTMR; t++) begin
         if (wr_take && idx == IDX_CTL0[t]) begin
            state_nxt.ctl0[t] = DAT_I[7:0];
         end
         if (wr_take && idx == IDX_CTL1[t]) begin
            state_nxt.ctl1[t] = DAT_I[7:0];
         end
      end

      // per-timer interrupt gating and dead-band outputs
      for (int t = 0; t < NTMR; t++) begin
         en   = state_r.ctl1[t][B_EN];
         pol  = state_r.ctl1[t][B_POL];
         dual = ({state_r.ctl0[t][B_MODE_HI],
                  state_r.ctl1[t][B_MODE_LO:0]} == MODE_PWM_DUAL);
         cfg  = state_r.ctl0[t][B_CFG_HI:B_CFG_LO];
         code = state_r.ctl0[t][B_DB_HI:B_DB_LO];

         // source select
         ev_all  = RELOAD_EVT[t] | COMPARE_EVT[t] | CAPTURE_EVT[t];
         cap_sel = CAPTURE_EVT[t] & (cfg != CFG_RLD_ONLY);
         if (cfg == CFG_CAP_ONLY) begin
            ev_sel = CAPTURE_EVT[t];
         end else if (cfg == CFG_RLD_ONLY) begin
            ev_sel = RELOAD_EVT[t] | COMPARE_EVT[t];
         end else begin
            ev_sel = ev_all;
         end
         set[t] = ev_sel;
         // capture wins the flag when it coincides with a reload, except under reload-only select
         if (ev_sel) begin
            state_nxt.ctl0[t][B_CAP] = cap_sel;
         end

         // code n>0 delays by 2^n cycles
         dly = (code == 3'h0) ? 8'h00 : (DLY_ONE << code);

         // active level is the complement of the polarity bit
         if (!en || !dual) begin
            state_nxt.main[t]      = pol;
            state_nxt.comp[t]      = ~pol;
            state_nxt.cnt[t]       = 8'h00;
            state_nxt.pend_main[t] = 1'b0;
            state_nxt.pend_comp[t] = 1'b0;
         end else if (RELOAD_EVT[t]) begin
            // reload beats a coincident match: main goes inactive at once
            state_nxt.main[t]      = pol;
            state_nxt.pend_main[t] = 1'b0;
            state_nxt.cnt[t]       = dly;
            state_nxt.comp[t]      = (dly == 8'h00) ? ~pol : pol;
            state_nxt.pend_comp[t] = (dly != 8'h00);
         end else if (PWM_MATCH_EVT[t]) begin
            state_nxt.comp[t]      = pol;
            state_nxt.pend_comp[t] = 1'b0;
            state_nxt.cnt[t]       = dly;
            state_nxt.main[t]      = (dly == 8'h00) ? ~pol : pol;
            state_nxt.pend_main[t] = (dly != 8'h00);
         end else if (state_r.cnt[t] != 8'h00) begin
            state_nxt.cnt[t] = state_r.cnt[t] - 8'h01;
            // the pending side goes active when the count expires
            if (state_r.cnt[t] == 8'h01) begin
               if (state_r.pend_main[t]) begin
                  state_nxt.main[t] = ~pol;
               end
               if (state_r.pend_comp[t]) begin
                  state_nxt.comp[t] = ~pol;
               end
               state_nxt.pend_main[t] = 1'b0;
               state_nxt.pend_comp[t] = 1'b0;
            end
         end
      end

      // sticky status, cleared by reading it; a new event wins the clear
      if (rd_done && idx == IDX_IRQ_STS) begin
         clr = state_r.dat[1:0];
      end
      state_nxt.sts = (state_r.sts & ~clr) | set;
      state_nxt.irq = |(state_nxt.sts & state_r.msk);

      if (SRST) begin
         state_nxt           = '0;
         state_nxt.ctl0      = {CTL_RST, CTL_RST};
         state_nxt.ctl1      = {CTL_RST, CTL_RST};
      end
   end

   // one register stage holds the whole block state
   always_ff @(posedge CLK) begin
      state_r <= state_nxt;
   end

   // every output comes straight from a state bit
   assign DAT_O    = {24'h000000, state_r.dat};
   assign ACK_O    = state_r.ack;
   assign TOUT     = state_r.main;
   assign TOUT_N   = state_r.comp;
   assign IRQ      = state_r.irq;
   for (genvar g = 0; g < NTMR; g++) begin : g_out
      assign TIMER_EN[g]       = state_r.ctl1[g][B_EN];
      assign TIMER_MODE[4*g+3] = state_r.ctl0[g][B_MODE_HI];
      assign TIMER_MODE[4*g+:3] = state_r.ctl1[g][B_MODE_LO:0];
   end

   // checks on timer 0; timer 1 shares the same code
   logic       dual0;
   logic       pol0;
   logic [1:0] cfg0;
   logic [2:0] code0;
   assign dual0 = (TIMER_MODE[3:0] == MODE_PWM_DUAL) & TIMER_EN[0];
   assign pol0  = state_r.ctl1[0][B_POL];
   assign cfg0  = state_r.ctl0[0][B_CFG_HI:B_CFG_LO];
   assign code0 = state_r.ctl0[0][B_DB_HI:B_DB_LO];

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   // write to control zero is stored as written
   ctl0_write_a: assert property (
      wr_take && idx == IDX_CTL0[0] && !(|(RELOAD_EVT | COMPARE_EVT
         | CAPTURE_EVT))
      |=> state_r.ctl0[0] == $past(DAT_I[7:0]))
      else $error("control zero write not stored");

   mode_top_bit_a: assert property (
      wr_take && idx == IDX_CTL0[0]
      |=> TIMER_MODE[3] == $past(DAT_I[7]))
      else $error("mode top bit does not follow write");

   irq_gate_a: assert property (
      cfg0 == CFG_RLD_ONLY && CAPTURE_EVT[0] && !RELOAD_EVT[0]
      && !COMPARE_EVT[0] && !state_r.sts[0] && !wr_take
      |=> !state_r.sts[0])
      else $error("capture raised irq while masked by select");

   cap_flag_a: assert property (
      cfg0 != CFG_RLD_ONLY && CAPTURE_EVT[0]
      |=> state_r.ctl0[0][B_CAP] && state_r.sts[0])
      else $error("capture interrupt did not set flag");

   rld_flag_a: assert property (
      cfg0 != CFG_CAP_ONLY && RELOAD_EVT[0] && !CAPTURE_EVT[0]
      |=> !state_r.ctl0[0][B_CAP])
      else $error("reload interrupt left capture flag set");

   reset_clear_a: assert property (
      disable iff (1'b0)
      SRST |=> state_r.ctl0 == '0 && TOUT == '0 && !IRQ)
      else $error("control zero not cleared by reset");

   db_none_a: assert property (
      dual0 && !pol0 && code0 == 3'h0 && PWM_MATCH_EVT[0]
      && !RELOAD_EVT[0] && !wr_take
      |=> TOUT[0] && !TOUT_N[0])
      else $error("zero dead-band did not switch at once");

   sequence match_two_s;
      dual0 && !pol0 && code0 == 3'h1 && PWM_MATCH_EVT[0]
      && !RELOAD_EVT[0] && !wr_take
      ##1 (!RELOAD_EVT[0] && !PWM_MATCH_EVT[0] && !wr_take)[*2];
   endsequence

   // main goes active on the edge after the two quiet cycles
   db_two_a: assert property (
      match_two_s |=> TOUT[0] && !$past(TOUT[0], 1) && !$past(TOUT[0], 2))
      else $error("two cycle dead-band timing wrong");

   reload_edge_a: assert property (
      dual0 && !pol0 && RELOAD_EVT[0] && !wr_take
      |=> !TOUT[0] && (code0 != 3'h0 || TOUT_N[0]))
      else $error("reload did not drive main inactive");

   no_overlap_a: assert property (
      dual0 && $stable(pol0)
      |-> !(TOUT[0] == !pol0 && TOUT_N[0] == !pol0))
      else $error("main and complement active together");

   ack_pulse_a: assert property (
      ACK_O |=> !ACK_O)
      else $error("ack held longer than one cycle");

   irq_level_a: assert property (
      (|(state_r.sts & state_r.msk)) |-> IRQ || $past(wr_take))
      else $error("unmasked status without interrupt");

   // main scenarios
   cov_db_long_c: cover property (
      dual0 && code0 == 3'h7 && PWM_MATCH_EVT[0] ##[128:130] TOUT[0]);
   cov_cap_irq_c: cover property (
      CAPTURE_EVT[0] && state_r.msk[0] ##1 IRQ);
   cov_rd_clear_c: cover property (
      rd_done && idx == IDX_IRQ_STS && state_r.dat[0] ##1 !state_r.sts[0]);
   cov_set_wins_c: cover property (
      rd_done && idx == IDX_IRQ_STS && state_r.dat[0] && RELOAD_EVT[0]);
endmodule
`default_nettype wire

// *** test/timer_ctl_deadband_tb.sv ***
// self-checking bench for the timer control-zero register block
`timescale 1ns/100ps
`default_nettype none
module timer_ctl_deadband_tb;
   import timer_ctl_pkg::*;
   logic              clk    = 1'b0;
   logic              srst   = 1'b1;
   logic              cyc    = 1'b0;
   logic              stb    = 1'b0;
   logic              we     = 1'b0;
   logic [ADR_W-1:0]  adr    = 16'h0000;
   logic [3:0]        sel    = 4'hF;
   logic [31:0]       dat_w  = 32'h0000_0000;
   logic [NTMR-1:0]   rld    = 2'h0;
   logic [NTMR-1:0]   cmp    = 2'h0;
   logic [NTMR-1:0]   cap    = 2'h0;
   logic [NTMR-1:0]   mat    = 2'h0;
   logic [31:0]       dat_r;
   logic              ack;
   logic [NTMR-1:0]   tout;
   logic [NTMR-1:0]   tout_n;
   logic [NTMR-1:0]   ten;
   logic [7:0]        mode_select_field;
   logic              irq;
   logic [31:0]       rnd    = 32'hD132;
   logic [31:0]       rd_q[$];
   int                fail_count = 0;
   int                tests_run  = 0;

   timer_ctl_deadband i_dut (.CLK(clk), .SRST(srst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .RELOAD_EVT(rld),
      .COMPARE_EVT(cmp), .CAPTURE_EVT(cap), .PWM_MATCH_EVT(mat),
      .DAT_O(dat_r), .ACK_O(ack), .TOUT(tout), .TOUT_N(tout_n),
      .TIMER_EN(ten), .TIMER_MODE(mode_select_field), .IRQ(irq));

   // free-running 250 MHz clock
   always #2 clk = ~clk;

   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg,
                  seen, exp);
      end
   endtask

   task automatic end_sim();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one classic cycle; a read notes its expected data for the monitor
   task automatic bus(input logic [11:0] idx, input logic w,
                      input logic [7:0] d, input logic [7:0] e);
      int n;
      @(posedge clk);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= {2'b00, idx, 2'b00};
      dat_w <= {24'h000000, d};
      if (!w) rd_q.push_back({24'h000000, e});
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) check(32'h0, 32'h1, "no bus answer");
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   // read data is judged at the edge that takes it, oldest note first
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
         check(dat_r, rd_q.pop_front(), "read data");
   end

   // one-cycle event on timer 0: 0 capture, 1 reload, 2 compare, 3 match
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: cap <= 2'h1;
         1: rld <= 2'h1;
         2: cmp <= 2'h1;
         default: mat <= 2'h1;
      endcase
      @(posedge clk);
      {cap, rld, cmp, mat} <= 8'h00;
   endtask

   // counts the dead-band; the side going active must wait, never overlap
   task automatic db_wait(input int k, input int code, input logic p);
      int   n;
      logic act;
      logic oth;
      pulse(k);
      #1;
      n = 0;
      act = (k == 3) ? tout[0] : tout_n[0];
      oth = (k == 3) ? tout_n[0] : tout[0];
      // active level is the inverse of the polarity bit p
      while (act !== ~p && n < 300) begin
         check(32'(oth), 32'(p), "overlap");
         @(posedge clk);
         #1;
         n++;
         act = (k == 3) ? tout[0] : tout_n[0];
         oth = (k == 3) ? tout_n[0] : tout[0];
      end
      check(32'(oth), 32'(p), "other side");
      check(32'(n), (code == 0) ? 32'h0 : 32'h1 << code, "delay");
   endtask

   initial begin
      #100000;
      fail_count++;
      end_sim();
   end

   initial begin
      logic [7:0] v;
      logic [7:0] m;
      logic [1:0] cfg;
      logic       msk;
      logic       csel;
      logic       esel;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      for (int t = 0; t < NTMR; t++) begin
         bus(IDX_CTL0[t], 1'b0, 8'h00, CTL_RST);
         bus(IDX_CTL1[t], 1'b0, 8'h00, CTL_RST);
      end
      // unmapped place: write ignored, reads zero
      bus(12'h0F0, 1'b1, 8'hFF, 8'h00);
      bus(12'h0F0, 1'b0, 8'h00, 8'h00);
      // random values on timer 1, mode top bit joins control-one mode bits
      repeat (4) begin
         v = 8'(xs());
         m = 8'(xs());
         bus(IDX_CTL0[1], 1'b1, v, 8'h00);
         bus(IDX_CTL1[1], 1'b1, m, 8'h00);
         bus(IDX_CTL0[1], 1'b0, 8'h00, v);
         repeat (2) @(posedge clk);
         #1;
         check(32'(mode_select_field[7:4]), 32'({v[7], m[2:0]}), "mode");
         check(32'(ten[1]), 32'(m[7]), "enable");
      end
      // every interrupt selection, with the mask closed for code 01
      for (int c = 0; c < 4; c++) begin
         cfg  = 2'(c);
         msk  = (c != 1);
         csel = (cfg != 2'h3);
         esel = (cfg != 2'h2);
         bus(IDX_IRQ_MSK, 1'b1, {7'h00, msk}, 8'h00);
         bus(IDX_CTL0[0], 1'b1, {1'b0, cfg, 5'h00}, 8'h00);
         pulse(0);
         @(posedge clk);
         #1;
         check(32'(irq), 32'(csel & msk), "irq on capture");
         bus(IDX_IRQ_STS, 1'b0, 8'h00, {7'h00, csel});
         @(posedge clk);
         #1;
         check(32'(irq), 32'h0, "irq after clear");
         bus(IDX_CTL0[0], 1'b0, 8'h00, {1'b0, cfg, 4'h0, csel});
         pulse(1 + c % 2);
         @(posedge clk);
         #1;
         check(32'(irq), 32'(esel & msk), "irq on reload");
         bus(IDX_IRQ_STS, 1'b0, 8'h00, {7'h00, esel});
         bus(IDX_CTL0[0], 1'b0, 8'h00,
             {1'b0, cfg, 4'h0, esel ? 1'b0 : csel});
      end
      // dual output, polarity 0, every dead-band code both ways
      bus(IDX_CTL1[0], 1'b1, {2'b10, 3'h0, MODE_PWM_DUAL[2:0]}, 8'h00);
      for (int code = 0; code < 8; code++) begin
         bus(IDX_CTL0[0], 1'b1, {MODE_PWM_DUAL[3], 3'h0, 3'(code), 1'b0},
             8'h00);
         db_wait(3, code, 1'b0);
         db_wait(1, code, 1'b0);
      end
      // polarity 1: active level low, four cycle dead-band both ways
      bus(IDX_CTL1[0], 1'b1, {2'b11, 3'h0, MODE_PWM_DUAL[2:0]}, 8'h00);
      bus(IDX_CTL0[0], 1'b1, {MODE_PWM_DUAL[3], 3'h0, 3'h2, 1'b0}, 8'h00);
      db_wait(3, 2, 1'b1);
      db_wait(1, 2, 1'b1);
      // reset in mid-run: outputs and control zero return to reset state
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      check(32'({tout, irq}), 32'h0, "reset outputs");
      check(32'(tout_n), 32'h3, "reset complement");
      for (int t = 0; t < NTMR; t++) begin
         bus(IDX_CTL0[t], 1'b0, 8'h00, CTL_RST);
      end
      end_sim();
   end
endmodule
`default_nettype wire
